// ===== core/lhie_irq_core.sv
/*
  Interrupt event and enable logic of a serial-bus link host controller:
  latched event bits, isochronous summaries, failed store location,
  enable register and one level interrupt. Avalon-MM slave with waitrequest.
  Assumes event inputs are one-cycle pulses synchronous to CLK_I and already
  qualified by each descriptor's interrupt condition.
*/
// Behaviour
// - Lock reply failure after exhausted retries sets event bit 9
// - Deferred store bus error sets bit 8 and records offset and source ID
// - Bit 7 is unlatched OR of receive context events AND enables
// - Bit 6 is unlatched OR of transmit context events AND enables
// - Each packet into reply receive buffer sets bit 5
// - Each packet into request receive buffer sets bit 4
// - Reply receive descriptor completion conditionally sets bit 3
// - Request receive descriptor completion conditionally sets bit 2
// - Reply send last-output completion conditionally sets bit 1
// - Request send last-output completion conditionally sets bit 0
// - Bus reinit setting bit 17 clears identity phase bit 16 same cycle
// - Software clear of bit 17 ignored during identity phase
// - Enable register mirrors events plus global enable at bit 31
// - Write one at set address sets, at clear address clears enable
// - Global enable zero blocks the interrupt entirely
// - Reading event-clear address returns events AND enables, any global enable
// - Reset clears global enable; other enable bits unspecified (reset here clears all enable bits)
// - Identity phase end sets bit 16 only when accept bit set
// - Link reporting bus reset sets bit 17
`timescale 1ns/1ps
module lhie_irq_core (
  input  wire logic                          CLK_I,              // System clock
  input  wire logic                          NRST_I,             // Async reset, low
  input  wire logic [lhie_pkg::ADDR_W-1:0]   AVS_ADDRESS_I,      // Byte address
  input  wire logic                          AVS_READ_I,         // Read request
  input  wire logic                          AVS_WRITE_I,        // Write request
  input  wire logic [lhie_pkg::DATA_W-1:0]   AVS_WRITEDATA_I,    // Write data
  input  wire logic [lhie_pkg::BE_W-1:0]     AVS_BYTEENABLE_I,   // Byte lanes
  output logic      [lhie_pkg::DATA_W-1:0]   AVS_READDATA_O,     // Read data
  output logic                               AVS_WAITREQUEST_O,  // Stall
  input  wire lhie_pkg::lhie_src_t           EVENT_I,            // Event pulses
  input  wire lhie_pkg::lhie_fail_t          FAIL_INFO_I,        // Failed store data
  input  wire lhie_pkg::lhie_iso_t           ISO_RX_I,           // Receive contexts
  input  wire lhie_pkg::lhie_iso_t           ISO_TX_I,           // Transmit contexts
  input  wire logic                          SELF_ID_PHASE_I,    // Identity phase on
  output logic                               IRQ_O,              // Interrupt level
  output logic                               ACCEPT_ID_O         // Accept identity bit
);

  localparam int DW = lhie_pkg::DATA_W;

  logic [DW-1:0]                   irq_event_bits;
  logic [DW-1:0]                   next_events;
  logic [DW-1:0]                   event_view;
  logic [DW-1:0]                   irq_enable_bits;
  logic [DW-1:0]                   next_rdata;
  logic [DW-1:0]                   wdata_be;
  logic [DW-1:0]                   hw_set;
  logic [DW-1:0]                   sw_set;
  logic [DW-1:0]                   sw_clr;
  logic [DW-1:0]                   mask_set;
  logic [DW-1:0]                   mask_clr;
  logic                            wr_fire;
  logic                            rd_take;
  logic                            iso_receive_summary;
  logic                            iso_transmit_summary;
  logic                            accept_identity_packets;
  logic [lhie_pkg::FAIL_OFS_W-1:0] failed_store_location;
  logic [lhie_pkg::SRC_ID_W-1:0]   failed_store_source;

  // Address match against one register offset
  function automatic logic addr_hit(input logic [lhie_pkg::ADDR_W-1:0] addr,
                                    input logic [lhie_pkg::ADDR_W-1:0] ofs);
    addr_hit = (addr == ofs);
  endfunction

  // Expand byte enables into a bit mask
  function automatic logic [DW-1:0] lane_mask(input logic [lhie_pkg::BE_W-1:0] be);
    logic [DW-1:0] m;
    m = '0;
    for (int i = 0; i < lhie_pkg::BE_W; i++) begin
      m[i*8 +: 8] = {8{be[i]}};
    end
    lane_mask = m;
  endfunction

  // Bus handshake: a write lands at the edge that sees waitrequest low
  assign wr_fire  = AVS_WRITE_I && !AVS_WAITREQUEST_O;
  assign rd_take  = AVS_READ_I && AVS_WAITREQUEST_O;
  assign wdata_be = AVS_WRITEDATA_I & lane_mask(AVS_BYTEENABLE_I);

  // Unlatched isochronous summaries
  assign iso_receive_summary  = |(ISO_RX_I.events & ISO_RX_I.enables);
  assign iso_transmit_summary = |(ISO_TX_I.events & ISO_TX_I.enables);

  // Full event view as software sees it
  always_comb begin
    event_view = irq_event_bits & lhie_pkg::LATCHED_BITS;
    event_view[lhie_pkg::BIT_ISO_RX_SUM] = iso_receive_summary;
    event_view[lhie_pkg::BIT_ISO_TX_SUM] = iso_transmit_summary;
  end

  // Hardware event sets
  always_comb begin
    hw_set = '0;
    hw_set[lhie_pkg::BIT_LOCK_FAIL]    = EVENT_I.lock_reply_failure;
    hw_set[lhie_pkg::BIT_STORE_FAIL]   = EVENT_I.deferred_store_failure;
    hw_set[lhie_pkg::BIT_REPLY_PKT]    = EVENT_I.reply_packet_done;
    hw_set[lhie_pkg::BIT_REQUEST_PKT]  = EVENT_I.request_packet_done;
    hw_set[lhie_pkg::BIT_REPLY_DESC]   = EVENT_I.reply_receive_descriptor_done;
    hw_set[lhie_pkg::BIT_REQUEST_DESC] = EVENT_I.request_receive_descriptor_done;
    hw_set[lhie_pkg::BIT_REPLY_SEND]   = EVENT_I.reply_send_done;
    hw_set[lhie_pkg::BIT_REQUEST_SEND] = EVENT_I.request_send_done;
    hw_set[lhie_pkg::BIT_BUS_REINIT]   = EVENT_I.bus_reinit_event;
    hw_set[lhie_pkg::BIT_ID_DONE]      = EVENT_I.node_identity_phase_done
                                         && accept_identity_packets;
  end

  // Software set and clear of latched events
  always_comb begin
    sw_set = '0;
    sw_clr = '0;
    if (wr_fire && addr_hit(AVS_ADDRESS_I, lhie_pkg::OFS_EVENT_SET)) begin
      sw_set = wdata_be & lhie_pkg::LATCHED_BITS;
    end else if (wr_fire && addr_hit(AVS_ADDRESS_I, lhie_pkg::OFS_EVENT_CLR)) begin
      sw_clr = wdata_be & lhie_pkg::LATCHED_BITS;
    end
    if (SELF_ID_PHASE_I) begin
      sw_clr[lhie_pkg::BIT_BUS_REINIT] = 1'b0;
    end
  end

  // Next events: sets win over clears, bus reinit kills identity done
  always_comb begin
    next_events = ((irq_event_bits & ~sw_clr) | sw_set | hw_set) & lhie_pkg::LATCHED_BITS;
    if (EVENT_I.bus_reinit_event) begin
      next_events[lhie_pkg::BIT_ID_DONE] = 1'b0;
    end
  end

  // Latched event register
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      irq_event_bits <= lhie_pkg::EVENT_RESET;
    end else begin
      irq_event_bits <= next_events;
    end
  end

  // Failed store location capture
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      failed_store_location <= lhie_pkg::FAIL_OFS_RESET;
      failed_store_source   <= lhie_pkg::SRC_ID_RESET;
    end else if (EVENT_I.deferred_store_failure) begin
      failed_store_location <= FAIL_INFO_I.offset;
      failed_store_source   <= FAIL_INFO_I.source_id;
    end
  end

  // Enable register strobes
  always_comb begin
    mask_set = '0;
    mask_clr = '0;
    if (wr_fire && addr_hit(AVS_ADDRESS_I, lhie_pkg::OFS_MASK_SET)) begin
      mask_set = wdata_be;
    end else if (wr_fire && addr_hit(AVS_ADDRESS_I, lhie_pkg::OFS_MASK_CLR)) begin
      mask_clr = wdata_be;
    end
  end

  lhie_mask_reg u_mask (
    .clk_i  (CLK_I),
    .nrst_i (NRST_I),
    .set_i  (mask_set),
    .clr_i  (mask_clr),
    .mask_o (irq_enable_bits)
  );

  // Link control: accept identity packets bit
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      accept_identity_packets <= 1'b0;
    end else if (wr_fire && addr_hit(AVS_ADDRESS_I, lhie_pkg::OFS_LINK_CTRL)
                 && AVS_BYTEENABLE_I[lhie_pkg::BIT_ACCEPT_ID/8]) begin
      accept_identity_packets <= AVS_WRITEDATA_I[lhie_pkg::BIT_ACCEPT_ID];
    end
  end

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      ACCEPT_ID_O <= 1'b0;
    end else begin
      ACCEPT_ID_O <= accept_identity_packets;
    end
  end

  // Interrupt level, gated by the global enable
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      IRQ_O <= 1'b0;
    end else begin
      IRQ_O <= irq_enable_bits[lhie_pkg::BIT_GLOBAL_EN]
               && |(event_view[DW-2:0] & irq_enable_bits[DW-2:0]);
    end
  end

  // Read multiplexer
  always_comb begin
    next_rdata = lhie_pkg::READ_DEFAULT;
    if (addr_hit(AVS_ADDRESS_I, lhie_pkg::OFS_EVENT_SET)) begin
      next_rdata = event_view;
    end else if (addr_hit(AVS_ADDRESS_I, lhie_pkg::OFS_EVENT_CLR)) begin
      next_rdata = event_view & {1'b0, irq_enable_bits[DW-2:0]};
    end else if (addr_hit(AVS_ADDRESS_I, lhie_pkg::OFS_MASK_SET)
                 || addr_hit(AVS_ADDRESS_I, lhie_pkg::OFS_MASK_CLR)) begin
      next_rdata = irq_enable_bits;
    end else if (addr_hit(AVS_ADDRESS_I, lhie_pkg::OFS_LINK_CTRL)) begin
      next_rdata[lhie_pkg::BIT_ACCEPT_ID] = accept_identity_packets;
    end else if (addr_hit(AVS_ADDRESS_I, lhie_pkg::OFS_FAIL_LO)) begin
      next_rdata = failed_store_location[DW-1:0];
    end else if (addr_hit(AVS_ADDRESS_I, lhie_pkg::OFS_FAIL_HI)) begin
      next_rdata = {failed_store_source, failed_store_location[lhie_pkg::FAIL_OFS_W-1:DW]};
    end
  end

  // Read data captured on the first request edge, held for the answer
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      AVS_READDATA_O <= lhie_pkg::READ_DEFAULT;
    end else if (rd_take) begin
      AVS_READDATA_O <= next_rdata;
    end
  end

  // One wait cycle per request, then release
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      AVS_WAITREQUEST_O <= 1'b1;
    end else begin
      AVS_WAITREQUEST_O <= !((AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O);
    end
  end

  // Checks next to the logic
  a_lock_fail_set: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    EVENT_I.lock_reply_failure |=> irq_event_bits[lhie_pkg::BIT_LOCK_FAIL])
    else $error("lock reply failure not latched");
  a_store_fail_log: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    EVENT_I.deferred_store_failure |=> irq_event_bits[lhie_pkg::BIT_STORE_FAIL]
      && failed_store_location == $past(FAIL_INFO_I.offset)
      && failed_store_source == $past(FAIL_INFO_I.source_id))
    else $error("store failure not latched or logged");
  a_iso_rx_read: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    (rd_take && addr_hit(AVS_ADDRESS_I, lhie_pkg::OFS_EVENT_SET))
      |=> AVS_READDATA_O[lhie_pkg::BIT_ISO_RX_SUM]
          == |($past(ISO_RX_I.events) & $past(ISO_RX_I.enables)))
    else $error("receive summary wrong");
  a_iso_tx_read: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    (rd_take && addr_hit(AVS_ADDRESS_I, lhie_pkg::OFS_EVENT_SET))
      |=> AVS_READDATA_O[lhie_pkg::BIT_ISO_TX_SUM]
          == |($past(ISO_TX_I.events) & $past(ISO_TX_I.enables)))
    else $error("transmit summary wrong");
  a_reply_pkt_set: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    EVENT_I.reply_packet_done |=> irq_event_bits[lhie_pkg::BIT_REPLY_PKT])
    else $error("reply packet event lost");
  a_request_pkt_set: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    EVENT_I.request_packet_done |=> irq_event_bits[lhie_pkg::BIT_REQUEST_PKT])
    else $error("request packet event lost");
  a_reply_desc_set: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    EVENT_I.reply_receive_descriptor_done |=> irq_event_bits[lhie_pkg::BIT_REPLY_DESC])
    else $error("reply descriptor event lost");
  a_request_desc_set: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    EVENT_I.request_receive_descriptor_done
      |=> irq_event_bits[lhie_pkg::BIT_REQUEST_DESC])
    else $error("request descriptor event lost");
  a_reply_send_set: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    EVENT_I.reply_send_done |=> irq_event_bits[lhie_pkg::BIT_REPLY_SEND])
    else $error("reply send event lost");
  a_request_send_set: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    EVENT_I.request_send_done |=> irq_event_bits[lhie_pkg::BIT_REQUEST_SEND])
    else $error("request send event lost");
  a_reinit_kills_id: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    EVENT_I.bus_reinit_event |=> irq_event_bits[lhie_pkg::BIT_BUS_REINIT]
      && !irq_event_bits[lhie_pkg::BIT_ID_DONE])
    else $error("bus reinit did not clear identity done");
  a_reinit_clear_lock: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    (SELF_ID_PHASE_I && irq_event_bits[lhie_pkg::BIT_BUS_REINIT] && wr_fire
     && addr_hit(AVS_ADDRESS_I, lhie_pkg::OFS_EVENT_CLR))
      |=> irq_event_bits[lhie_pkg::BIT_BUS_REINIT])
    else $error("bus reinit cleared during identity phase");
  a_global_gate: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    !irq_enable_bits[lhie_pkg::BIT_GLOBAL_EN] |=> !IRQ_O)
    else $error("interrupt with global enable off");
  a_clear_read_mask: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    (rd_take && addr_hit(AVS_ADDRESS_I, lhie_pkg::OFS_EVENT_CLR))
      |=> AVS_READDATA_O == ($past(event_view) & $past(irq_enable_bits)
                             & {1'b0, {(DW-1){1'b1}}}))
    else $error("event clear read not masked");
  a_id_needs_accept: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    (EVENT_I.node_identity_phase_done && !accept_identity_packets
     && !irq_event_bits[lhie_pkg::BIT_ID_DONE] && !wr_fire)
      |=> !irq_event_bits[lhie_pkg::BIT_ID_DONE])
    else $error("identity done set without accept");
  a_irq_level: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    (irq_enable_bits[lhie_pkg::BIT_GLOBAL_EN]
     && |(event_view[DW-2:0] & irq_enable_bits[DW-2:0])) |=> IRQ_O)
    else $error("enabled event raised no interrupt");

  c_irq_raised:   cover property (@(posedge CLK_I) disable iff (!NRST_I) $rose(IRQ_O));
  c_reinit_in_id: cover property (@(posedge CLK_I) disable iff (!NRST_I)
    EVENT_I.bus_reinit_event && irq_event_bits[lhie_pkg::BIT_ID_DONE]);
  c_clear_read:   cover property (@(posedge CLK_I) disable iff (!NRST_I)
    rd_take && addr_hit(AVS_ADDRESS_I, lhie_pkg::OFS_EVENT_CLR));
  c_store_fail:   cover property (@(posedge CLK_I) disable iff (!NRST_I)
    EVENT_I.deferred_store_failure);

endmodule // lhie_irq_core

// ===== common/lhie_pkg.sv
/*
  Shared constants and carrier types for the link host interrupt event block:
  register offsets, bit positions, implemented-bit masks and reset values.
  Assumes an Avalon-MM slave with byte addresses and 32-bit data.
*/
package lhie_pkg;

  // Bus geometry
  localparam int ADDR_W      = 8;
  localparam int DATA_W      = 32;
  localparam int BE_W        = 4;
  localparam int CTX_W       = 8;
  localparam int FAIL_OFS_W  = 48;
  localparam int SRC_ID_W    = 16;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_EVENT_SET = 8'h80;
  localparam logic [ADDR_W-1:0] OFS_EVENT_CLR = 8'h84;
  localparam logic [ADDR_W-1:0] OFS_MASK_SET  = 8'h88;
  localparam logic [ADDR_W-1:0] OFS_MASK_CLR  = 8'h8c;
  localparam logic [ADDR_W-1:0] OFS_LINK_CTRL = 8'he0;
  localparam logic [ADDR_W-1:0] OFS_FAIL_LO   = 8'h38;
  localparam logic [ADDR_W-1:0] OFS_FAIL_HI   = 8'h3c;

  // Event bit positions
  localparam int BIT_REQUEST_SEND   = 0;
  localparam int BIT_REPLY_SEND     = 1;
  localparam int BIT_REQUEST_DESC   = 2;
  localparam int BIT_REPLY_DESC     = 3;
  localparam int BIT_REQUEST_PKT    = 4;
  localparam int BIT_REPLY_PKT      = 5;
  localparam int BIT_ISO_TX_SUM     = 6;
  localparam int BIT_ISO_RX_SUM     = 7;
  localparam int BIT_STORE_FAIL     = 8;
  localparam int BIT_LOCK_FAIL      = 9;
  localparam int BIT_ID_DONE        = 16;
  localparam int BIT_BUS_REINIT     = 17;
  localparam int BIT_GLOBAL_EN      = 31;
  localparam int BIT_ACCEPT_ID      = 9;

  // Latched event bits, implemented enable bits, reset values
  localparam logic [DATA_W-1:0] LATCHED_BITS    = 32'h0003_033f;
  localparam logic [DATA_W-1:0] MASK_IMPL       = 32'h8003_03ff;
  localparam logic [DATA_W-1:0] EVENT_RESET     = 32'h0000_0000;
  localparam logic [DATA_W-1:0] MASK_RESET      = 32'h0000_0000;
  localparam logic [DATA_W-1:0] READ_DEFAULT    = 32'h0000_0000;
  localparam logic [FAIL_OFS_W-1:0] FAIL_OFS_RESET = 48'h0000_0000_0000;
  localparam logic [SRC_ID_W-1:0]   SRC_ID_RESET   = 16'h0000;

  // One-cycle event pulses from the DMA contexts and the link
  typedef struct packed {
    logic lock_reply_failure;
    logic deferred_store_failure;
    logic reply_packet_done;
    logic request_packet_done;
    logic reply_receive_descriptor_done;
    logic request_receive_descriptor_done;
    logic reply_send_done;
    logic request_send_done;
    logic bus_reinit_event;
    logic node_identity_phase_done;
  } lhie_src_t;

  // Location of a failed deferred store
  typedef struct packed {
    logic [FAIL_OFS_W-1:0] offset;
    logic [SRC_ID_W-1:0]   source_id;
  } lhie_fail_t;

  // Isochronous context events and enables
  typedef struct packed {
    logic [CTX_W-1:0] events;
    logic [CTX_W-1:0] enables;
  } lhie_iso_t;

endpackage

// ===== core/lhie_mask_reg.sv
/*
  Interrupt enable register with separate set and clear strobes.
  Assumes the strobes are already gated by a completed bus write and byte lanes.
*/
`timescale 1ns/1ps
module lhie_mask_reg (
  input  wire logic                        clk_i,   // System clock
  input  wire logic                        nrst_i,  // Async reset, active low
  input  wire logic [lhie_pkg::DATA_W-1:0] set_i,   // Bits to set
  input  wire logic [lhie_pkg::DATA_W-1:0] clr_i,   // Bits to clear
  output logic      [lhie_pkg::DATA_W-1:0] mask_o   // Enable bits
);

  logic [lhie_pkg::DATA_W-1:0] next_mask;

  // Write-one-to-set and write-one-to-clear on implemented bits
  always_comb begin
    next_mask = ((mask_o | set_i) & ~clr_i) & lhie_pkg::MASK_IMPL;
  end

  // Global enable comes up cleared
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mask_o <= lhie_pkg::MASK_RESET;
    end else begin
      mask_o <= next_mask;
    end
  end

  a_mask_set_bits: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (set_i != '0) |=> ((mask_o & $past(set_i & lhie_pkg::MASK_IMPL))
                      == $past(set_i & lhie_pkg::MASK_IMPL)))
    else $error("mask set did not take");
  a_mask_clr_bits: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (clr_i != '0) |=> ((mask_o & $past(clr_i)) == '0))
    else $error("mask clear did not take");
  a_master_reset: assert property (@(posedge clk_i) disable iff (!nrst_i)
    $rose(nrst_i) |-> !mask_o[lhie_pkg::BIT_GLOBAL_EN])
    else $error("global enable set after reset");

endmodule // lhie_mask_reg

// ===== dv/lhie_evt_src.sv
/*
  Event source model: DMA contexts and link raising event pulses,
  failed store data and isochronous context levels.
  Assumes the bench calls fire and sets the level outputs directly.
*/
`timescale 1ns/1ps
module lhie_evt_src (
  input  wire logic            clk_i,  // System clock
  output lhie_pkg::lhie_src_t  ev_o,   // Event pulses
  output lhie_pkg::lhie_fail_t fail_o, // Failed store data
  output lhie_pkg::lhie_iso_t  rx_o,   // Receive contexts
  output lhie_pkg::lhie_iso_t  tx_o    // Transmit contexts
);
  // Quiet sources at start
  initial begin
    ev_o = '0;
    fail_o = '0;
    rx_o = '0;
    tx_o = '0;
  end
  // One-cycle pulse, launched just after an edge
  task automatic fire(input lhie_pkg::lhie_src_t p);
    @(posedge clk_i);
    ev_o <= p;
    @(posedge clk_i);
    ev_o <= '0;
  endtask
endmodule // lhie_evt_src

// ===== dv/tb_link_host_interrupt_events.sv
/*
  Self-checking bench for the interrupt event block over Avalon-MM.
  Assumes the package offsets; the bus master waits for waitrequest low
  at a rising edge, until the hang guard ends the run at 3000 cycles.
*/
`timescale 1ns/1ps
module tb_link_host_interrupt_events;
  logic                 clk = 1'b0;
  logic                 nrst = 1'b0;
  logic [7:0]           addr = '0;
  logic                 rd = 1'b0;
  logic                 wr = 1'b0;
  logic [31:0]          wdata = '0;
  logic                 phase = 1'b0;
  logic [31:0]          rdata;
  logic                 waitreq;
  logic                 irq;
  logic                 acc;
  logic [31:0]          got;
  logic [31:0]          exp;
  lhie_pkg::lhie_src_t  ev;
  lhie_pkg::lhie_fail_t fail;
  lhie_pkg::lhie_iso_t  rx;
  lhie_pkg::lhie_iso_t  tx;
  int                   miscompares = 0;
  int                   num_checks = 0;
  int                   cycles = 0;
  int                   k;

  always #10 clk = ~clk;

  lhie_evt_src src (.clk_i(clk), .ev_o(ev), .fail_o(fail), .rx_o(rx), .tx_o(tx));

  lhie_irq_core dut (
    .CLK_I(clk), .NRST_I(nrst), .AVS_ADDRESS_I(addr), .AVS_READ_I(rd),
    .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdata), .AVS_BYTEENABLE_I(4'hf),
    .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(waitreq), .EVENT_I(ev),
    .FAIL_INFO_I(fail), .ISO_RX_I(rx), .ISO_TX_I(tx),
    .SELF_ID_PHASE_I(phase), .IRQ_O(irq), .ACCEPT_ID_O(acc));

  // Compare and count
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // One bus cycle, held until a rising edge samples waitrequest low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    rd <= ~w;
    wr <= w;
    addr <= a;
    wdata <= d;
    do begin
      @(posedge clk);
    end while (waitreq !== 1'b0);
    got = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, '0);
    chk(got, e);
  endtask

  // Irq level a few cycles after a change
  task automatic irq_chk(input logic e);
    repeat (3) @(negedge clk);
    chk({31'h0, irq}, {31'h0, e});
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      wrap_up();
    end
  end

  // Main sequence
  initial begin
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    rd_chk(8'h88, 32'h0);
    rd_chk(8'hf0, 32'h0);
    bus(1'b1, 8'h88, 32'h8003_03ff);
    rd_chk(8'h8c, 32'h8003_03ff);
    bus(1'b1, 8'h8c, 32'h8000_0000);
    rd_chk(8'h88, 32'h0003_03ff);
    src.fail_o <= {48'h1234_5678_9abc, 16'hfedc};
    exp = '0;
    for (k = 2; k < 10; k++) begin
      src.fire(lhie_pkg::lhie_src_t'(10'h1 << k));
      exp[k > 7 ? k : k - 2] = 1'b1;
      rd_chk(8'h80, exp);
      irq_chk(1'b0);
    end
    rd_chk(8'h84, 32'h0000_033f);
    rd_chk(8'h38, 32'h5678_9abc);
    rd_chk(8'h3c, 32'hfedc_1234);
    bus(1'b1, 8'h88, 32'h8000_0000);
    irq_chk(1'b1);
    bus(1'b1, 8'h8c, 32'h0000_033f);
    irq_chk(1'b0);
    rd_chk(8'h84, 32'h0);
    bus(1'b1, 8'h84, 32'h0000_033f);
    rd_chk(8'h80, 32'h0);
    // Isochronous summaries follow context levels
    src.rx_o <= 16'h0404;
    rd_chk(8'h80, 32'h0000_0080);
    src.rx_o <= 16'h0402;
    rd_chk(8'h80, 32'h0);
    src.tx_o <= 16'h8080;
    rd_chk(8'h80, 32'h0000_0040);
    src.tx_o <= 16'h8040;
    rd_chk(8'h80, 32'h0);
    // Identity phase and bus reinit interplay
    src.fire(lhie_pkg::lhie_src_t'(10'h001));
    rd_chk(8'h80, 32'h0);
    bus(1'b1, 8'he0, 32'h0000_0200);
    // Accept copy trails the control bit by one cycle
    repeat (2) @(negedge clk);
    chk({31'h0, acc}, 32'h1);
    src.fire(lhie_pkg::lhie_src_t'(10'h001));
    rd_chk(8'h80, 32'h0001_0000);
    src.fire(lhie_pkg::lhie_src_t'(10'h003));
    rd_chk(8'h80, 32'h0002_0000);
    phase <= 1'b1;
    bus(1'b1, 8'h84, 32'h0002_0000);
    rd_chk(8'h80, 32'h0002_0000);
    phase <= 1'b0;
    // Identity phase is off here before the clear
    bus(1'b1, 8'h84, 32'h0002_0000);
    rd_chk(8'h80, 32'h0);
    wrap_up();
  end
endmodule // tb_link_host_interrupt_events
